// [rtl/cir_pkg.sv]
// ---------------------------------------------------------------
// cir_pkg: constants for the control input routing block
// ---------------------------------------------------------------
// assumes a single 25 MHz clock and an AXI4-Lite register port.
// switch n of a switchgroup sits at register bit n-1.
//
// Operation
// RULE_01: all three blocking bits zero means the first input blocks nothing.
// RULE_02: switch 1 set: active first input blocks both overload stages.
// RULE_03: switch 2 set: active first input blocks both unbalance stages.
// RULE_04: switch 3 set: active first input blocks the undercurrent stage.
// RULE_05: switch 4 enables first input control of reconnection inhibit.
// RULE_06: switch 5 set: active first input drives the trip relay.
// RULE_07: an external trip never sets the device's own trip indication.
// RULE_08: switch 6 set: active first input clears trip indicators.
// RULE_09: switch 7 set: first input clears indicators and releases relays.
// RULE_10: switch 8 set: active first input gives a master reset.
// RULE_11: all three blocking bits zero means the remote input blocks nothing.
// RULE_12: switch 1 set: active remote input blocks both overload stages.
// RULE_13: switch 2 set: active remote input blocks both unbalance stages.
// RULE_14: switch 3 set: active remote input blocks the undercurrent stage.
// RULE_15: switch 4 enables remote input control of reconnection inhibit.
// RULE_16: switch 5 set: active remote input drives the trip relay.
// RULE_17: switch 6 set: active remote input clears trip indicators.
// RULE_18: switch 7 set: remote input clears indicators and releases relays.
// RULE_19: switch 8 set: active remote input gives a master reset.
// RULE_20: inputs are synchronised; switchgroups reset to zero.
// RULE_21: the outside party holds an input active two clocks at least.

`default_nettype none

package cir_pkg;

	localparam int AXI_AW = 8;
	localparam int AXI_DW = 32;
	localparam int CFG_W = 8;

	// ---------------------------------------------------------------
	// register map
	// ---------------------------------------------------------------
	localparam logic [AXI_AW-1:0] OFS_FIRST_CFG = 8'h00;
	localparam logic [AXI_AW-1:0] OFS_REMOTE_CFG = 8'h04;
	localparam logic [AXI_AW-1:0] OFS_STATUS = 8'h08;
	localparam logic [CFG_W-1:0] CFG_RESET = 8'h00;
	localparam int CFG_STRB_LANE = 0;

	// ---------------------------------------------------------------
	// switch positions within a switchgroup
	// ---------------------------------------------------------------
	localparam int SW_BLK_OVL = 0;
	localparam int SW_BLK_UNB = 1;
	localparam int SW_BLK_UND = 2;
	localparam int SW_INHIBIT = 3;
	localparam int SW_TRIP = 4;
	localparam int SW_CLR_IND = 5;
	localparam int SW_CLR_ALL = 6;
	localparam int SW_MASTER = 7;
	localparam logic [2:0] BLK_NONE = 3'h0;

	// status word: [0] first input level, [1] remote level, [9:2] actions
	localparam int ST_LVL_FIRST = 0;
	localparam int ST_LVL_REMOTE = 1;
	localparam int ST_ACT_LSB = 2;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

`default_nettype wire

// [rtl/cir_sync.sv]
// ---------------------------------------------------------------
// cir_sync: two-stage synchroniser for the two control inputs
// ---------------------------------------------------------------
// inputs come from field contacts with no timing relation to clk.

`default_nettype none

module cir_sync
	import cir_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [1:0] raw,
	output logic [1:0] level
);

	typedef struct packed {
		logic [1:0] meta;
		logic [1:0] safe;
	} cir_sync_t;

	cir_sync_t q_r;
	cir_sync_t q_nxt;

	// first stage feeds only the second stage
	always_comb begin
		q_nxt = q_r;
		q_nxt.meta = raw; // [RULE_20]
		q_nxt.safe = q_r.meta;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q_r <= '0;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign level = q_r.safe;

endmodule

`default_nettype wire

// [rtl/cir_top.sv]
// ---------------------------------------------------------------
// cir_top: routing of the two external control inputs
// ---------------------------------------------------------------
// each input is qualified by its own switchgroup; the resulting
// block, trip and reset requests go to the protection logic.
// assumes field inputs are held active for two clocks or more.

`default_nettype none

module cir_top
	import cir_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic first_control_input,
	input wire logic remote_reset_input,
	input wire logic [AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [AXI_DW-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [AXI_DW-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic block_overload,
	output logic block_unbalance,
	output logic block_undercurrent,
	output logic inhibit_ext_ctrl,
	output logic ext_trip,
	output logic clear_indicators,
	output logic release_relays,
	output logic master_reset
);

	typedef struct packed {
		logic [CFG_W-1:0] first_cfg;
		logic [CFG_W-1:0] remote_cfg;
		logic aw_full;
		logic [AXI_AW-1:0] awaddr;
		logic w_full;
		logic [AXI_DW-1:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [AXI_DW-1:0] rdata;
		logic [1:0] rresp;
		logic [CFG_W-1:0] act;
	} cir_state_t;

	cir_state_t q_r;
	cir_state_t q_nxt;
	logic [1:0] level;
	logic lvl_first;
	logic lvl_remote;

	// ---------------------------------------------------------------
	// input synchronisation
	// ---------------------------------------------------------------
	// a pulse shorter than one clock may be missed entirely
	cir_sync u_sync (
		.clk(clk),
		.rst(rst),
		.raw({remote_reset_input, first_control_input}), // [RULE_21]
		.level(level)
	);

	assign lvl_first = level[0];
	assign lvl_remote = level[1];

	// an input acts on a function only while its switch is on
	function automatic logic route(input logic a, input logic [CFG_W-1:0] ca,
			input logic b, input logic [CFG_W-1:0] cb, input int pos);
		route = (a & ca[pos]) | (b & cb[pos]);
	endfunction

	function automatic logic is_cfg(input logic [AXI_AW-1:0] addr);
		is_cfg = (addr == OFS_FIRST_CFG) || (addr == OFS_REMOTE_CFG);
	endfunction

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		q_nxt = q_r;

		// routed actions
		q_nxt.act[SW_BLK_OVL] = route(lvl_first, q_r.first_cfg, lvl_remote,
			q_r.remote_cfg, SW_BLK_OVL); // [RULE_01] [RULE_02] [RULE_11] [RULE_12]
		q_nxt.act[SW_BLK_UNB] = route(lvl_first, q_r.first_cfg, lvl_remote,
			q_r.remote_cfg, SW_BLK_UNB); // [RULE_03] [RULE_13]
		q_nxt.act[SW_BLK_UND] = route(lvl_first, q_r.first_cfg, lvl_remote,
			q_r.remote_cfg, SW_BLK_UND); // [RULE_04] [RULE_14]
		q_nxt.act[SW_INHIBIT] = route(lvl_first, q_r.first_cfg, lvl_remote,
			q_r.remote_cfg, SW_INHIBIT); // [RULE_05] [RULE_15]
		// the trip goes to the relay only; no indication is raised
		q_nxt.act[SW_TRIP] = route(lvl_first, q_r.first_cfg, lvl_remote,
			q_r.remote_cfg, SW_TRIP); // [RULE_06] [RULE_07] [RULE_16]
		// the wider reset also clears the indicators
		q_nxt.act[SW_CLR_IND] = route(lvl_first, q_r.first_cfg, lvl_remote,
			q_r.remote_cfg, SW_CLR_IND) | route(lvl_first, q_r.first_cfg,
			lvl_remote, q_r.remote_cfg, SW_CLR_ALL); // [RULE_08] [RULE_17]
		q_nxt.act[SW_CLR_ALL] = route(lvl_first, q_r.first_cfg, lvl_remote,
			q_r.remote_cfg, SW_CLR_ALL); // [RULE_09] [RULE_18]
		q_nxt.act[SW_MASTER] = route(lvl_first, q_r.first_cfg, lvl_remote,
			q_r.remote_cfg, SW_MASTER); // [RULE_10] [RULE_19]

		// write channel: address and data taken in either order
		if (s_axi_awvalid && q_r.awready) begin
			q_nxt.aw_full = 1'b1;
			q_nxt.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && q_r.wready) begin
			q_nxt.w_full = 1'b1;
			q_nxt.wdata = s_axi_wdata;
			q_nxt.wstrb = s_axi_wstrb;
		end
		if (q_r.bvalid && s_axi_bready) begin
			q_nxt.bvalid = 1'b0;
		end
		if (q_r.aw_full && q_r.w_full && !q_r.bvalid) begin
			q_nxt.aw_full = 1'b0;
			q_nxt.w_full = 1'b0;
			q_nxt.bvalid = 1'b1;
			q_nxt.bresp = is_cfg(q_r.awaddr) ? RESP_OKAY : RESP_SLVERR;
			if (q_r.wstrb[CFG_STRB_LANE]) begin
				if (q_r.awaddr == OFS_FIRST_CFG) begin
					q_nxt.first_cfg = q_r.wdata[CFG_W-1:0];
				end
				if (q_r.awaddr == OFS_REMOTE_CFG) begin
					q_nxt.remote_cfg = q_r.wdata[CFG_W-1:0];
				end
			end
		end
		// one write in flight: ready falls once a half is held
		q_nxt.awready = !q_nxt.aw_full && !q_nxt.bvalid;
		q_nxt.wready = !q_nxt.w_full && !q_nxt.bvalid;

		// read channel
		if (q_r.rvalid && s_axi_rready) begin
			q_nxt.rvalid = 1'b0;
		end
		if (s_axi_arvalid && q_r.arready) begin
			q_nxt.rvalid = 1'b1;
			q_nxt.rresp = RESP_OKAY;
			q_nxt.rdata = '0;
			case (s_axi_araddr)
				OFS_FIRST_CFG: begin
					q_nxt.rdata[CFG_W-1:0] = q_r.first_cfg;
				end
				OFS_REMOTE_CFG: begin
					q_nxt.rdata[CFG_W-1:0] = q_r.remote_cfg;
				end
				OFS_STATUS: begin
					q_nxt.rdata[ST_LVL_FIRST] = lvl_first;
					q_nxt.rdata[ST_LVL_REMOTE] = lvl_remote;
					q_nxt.rdata[ST_ACT_LSB +: CFG_W] = q_r.act;
				end
				default: begin
					q_nxt.rresp = RESP_SLVERR;
				end
			endcase
		end
		q_nxt.arready = !q_nxt.rvalid;
	end

	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q_r <= '0; // [RULE_20]
		end else begin
			q_r <= q_nxt;
		end
	end

	assign s_axi_awready = q_r.awready;
	assign s_axi_wready = q_r.wready;
	assign s_axi_bvalid = q_r.bvalid;
	assign s_axi_bresp = q_r.bresp;
	assign s_axi_arready = q_r.arready;
	assign s_axi_rvalid = q_r.rvalid;
	assign s_axi_rdata = q_r.rdata;
	assign s_axi_rresp = q_r.rresp;
	assign block_overload = q_r.act[SW_BLK_OVL];
	assign block_unbalance = q_r.act[SW_BLK_UNB];
	assign block_undercurrent = q_r.act[SW_BLK_UND];
	assign inhibit_ext_ctrl = q_r.act[SW_INHIBIT];
	assign ext_trip = q_r.act[SW_TRIP];
	assign clear_indicators = q_r.act[SW_CLR_IND];
	assign release_relays = q_r.act[SW_CLR_ALL];
	assign master_reset = q_r.act[SW_MASTER];

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	chk_no_block: assert property ( // [RULE_01] [RULE_11]
		(q_r.first_cfg[SW_BLK_UND:SW_BLK_OVL] == BLK_NONE)
		&& (q_r.remote_cfg[SW_BLK_UND:SW_BLK_OVL] == BLK_NONE)
		|=> !block_overload && !block_unbalance && !block_undercurrent)
		else $error("blocking raised with all blocking switches off");

	chk_ovl_block: assert property ( // [RULE_02] [RULE_12]
		##1 block_overload == ($past(lvl_first && q_r.first_cfg[SW_BLK_OVL])
		|| $past(lvl_remote && q_r.remote_cfg[SW_BLK_OVL])))
		else $error("overload blocking does not follow its inputs");

	chk_unb_block: assert property ( // [RULE_03] [RULE_13]
		lvl_first && q_r.first_cfg[SW_BLK_UNB]
		|| lvl_remote && q_r.remote_cfg[SW_BLK_UNB] |=> block_unbalance)
		else $error("unbalance stages not blocked");

	chk_und_block: assert property ( // [RULE_04] [RULE_14]
		$rose(block_undercurrent) |-> $past(lvl_first && q_r.first_cfg[SW_BLK_UND]
		|| lvl_remote && q_r.remote_cfg[SW_BLK_UND]))
		else $error("undercurrent blocked without cause");

	chk_inhibit_gate: assert property ( // [RULE_05] [RULE_15]
		!q_r.first_cfg[SW_INHIBIT] && !q_r.remote_cfg[SW_INHIBIT] |=> !inhibit_ext_ctrl)
		else $error("inhibit control active while disabled");

	chk_ext_trip: assert property ( // [RULE_06] [RULE_16]
		first_control_input && q_r.first_cfg[SW_TRIP] && $stable(q_r.first_cfg)
		##1 first_control_input && $stable(q_r.first_cfg)
		##1 first_control_input && $stable(q_r.first_cfg) |=> ext_trip)
		else $error("external trip not passed within three clocks");

	chk_no_indication: assert property ( // [RULE_07] [RULE_08] [RULE_17]
		clear_indicators |-> $past(lvl_first && (q_r.first_cfg[SW_CLR_IND]
		|| q_r.first_cfg[SW_CLR_ALL]) || lvl_remote && (q_r.remote_cfg[SW_CLR_IND]
		|| q_r.remote_cfg[SW_CLR_ALL])))
		else $error("indicator clear without a selected input");

	chk_release_all: assert property ( // [RULE_09] [RULE_18]
		release_relays |-> clear_indicators)
		else $error("relays released without clearing indicators");

	chk_master_rst: assert property ( // [RULE_10] [RULE_19]
		##1 master_reset == ($past(lvl_first && q_r.first_cfg[SW_MASTER])
		|| $past(lvl_remote && q_r.remote_cfg[SW_MASTER])))
		else $error("master reset does not follow its inputs");

	chk_sync_delay: assert property ( // [RULE_20]
		##2 level == $past({remote_reset_input, first_control_input}, 2))
		else $error("synchroniser latency is not two clocks");

	chk_bresp_once: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before taken");

	chk_rvalid_hold: assert property (
		s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read data dropped before taken");

	// one write and one read in flight: nothing new while an answer waits
	chk_wr_refuse: assert property (
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while a response waits");

	chk_rd_refuse: assert property (
		s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while read data waits");

	chk_wr_reopen: assert property (
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
		else $error("write channel not reopened after response");

	chk_rd_reopen: assert property (
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
		else $error("read channel not reopened after data");

	chk_bvalid_late: assert property (
		q_r.aw_full && q_r.w_full && !s_axi_bvalid |=> s_axi_bvalid && !q_r.aw_full && !q_r.w_full)
		else $error("write response not given one clock after both halves");

	// a refused write must leave both switchgroups as they were
	chk_wr_slverr: assert property (
		s_axi_bvalid && (s_axi_bresp == RESP_SLVERR)
		|-> $stable(q_r.first_cfg) && $stable(q_r.remote_cfg))
		else $error("refused write changed a switchgroup");

	chk_rd_slverr: assert property (
		s_axi_rvalid && (s_axi_rresp == RESP_SLVERR) |-> (s_axi_rdata == '0))
		else $error("refused read returned data");

	chk_cfg_first: assert property (
		q_r.aw_full && q_r.w_full && !s_axi_bvalid && q_r.wstrb[CFG_STRB_LANE]
		&& (q_r.awaddr == OFS_FIRST_CFG) |=> q_r.first_cfg == $past(q_r.wdata[CFG_W-1:0]))
		else $error("first switchgroup write lost");

	chk_cfg_remote: assert property (
		q_r.aw_full && q_r.w_full && !s_axi_bvalid && q_r.wstrb[CFG_STRB_LANE]
		&& (q_r.awaddr == OFS_REMOTE_CFG) |=> q_r.remote_cfg == $past(q_r.wdata[CFG_W-1:0]))
		else $error("remote switchgroup write lost");

	chk_cfg_keep: assert property (
		!(q_r.aw_full && q_r.w_full && !s_axi_bvalid) |=> $stable(q_r.first_cfg) && $stable(q_r.remote_cfg))
		else $error("switchgroup changed without a write");

	chk_unb_clear: assert property ( // [RULE_03] [RULE_13]
		!(lvl_first && q_r.first_cfg[SW_BLK_UNB]) && !(lvl_remote && q_r.remote_cfg[SW_BLK_UNB])
		|=> !block_unbalance)
		else $error("unbalance stages blocked without cause");

	chk_und_on: assert property ( // [RULE_04] [RULE_14]
		lvl_first && q_r.first_cfg[SW_BLK_UND]
		|| lvl_remote && q_r.remote_cfg[SW_BLK_UND] |=> block_undercurrent)
		else $error("undercurrent stage not blocked");

	chk_inhibit_on: assert property ( // [RULE_05] [RULE_15]
		lvl_first && q_r.first_cfg[SW_INHIBIT]
		|| lvl_remote && q_r.remote_cfg[SW_INHIBIT] |=> inhibit_ext_ctrl)
		else $error("inhibit control not enabled");

	chk_trip_cause: assert property ( // [RULE_06] [RULE_16]
		$rose(ext_trip) |-> $past(lvl_first && q_r.first_cfg[SW_TRIP]
		|| lvl_remote && q_r.remote_cfg[SW_TRIP]))
		else $error("trip relay driven without cause");

	chk_release_follow: assert property ( // [RULE_09] [RULE_18]
		##1 release_relays == ($past(lvl_first && q_r.first_cfg[SW_CLR_ALL])
		|| $past(lvl_remote && q_r.remote_cfg[SW_CLR_ALL])))
		else $error("relay release does not follow its inputs");

	cov_ext_trip: cover property ($rose(ext_trip));
	cov_master: cover property ($rose(master_reset));
	cov_cfg_write: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == RESP_OKAY);
	cov_slow_bresp: cover property (s_axi_bvalid && !s_axi_bready);
	cov_both_inputs: cover property (lvl_first && lvl_remote);

endmodule

`default_nettype wire

// [verif/cir_field_model.sv]
// cir_field_model: field contacts driving the two control inputs
// assumes commands from the bench change only just after a rising edge
`default_nettype none

module cir_field_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic cmd_first,
	input wire logic cmd_remote,
	output logic first_control_input,
	output logic remote_reset_input
);
	timeunit 1ns;
	timeprecision 1ns;

	// ---------------------------------------------------------------
	// contacts
	// ---------------------------------------------------------------
	// a contact lags its command by one clock; each command is held for
	// many clocks, well above the two-clock minimum
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			first_control_input <= 1'b0;
			remote_reset_input <= 1'b0;
		end else begin
			first_control_input <= cmd_first;
			remote_reset_input <= cmd_remote;
		end
	end
endmodule

`default_nettype wire

// [verif/cir_top_tb.sv]
// cir_top_tb: self-checking bench for the control input routing block
// assumes cir_top with its AXI4-Lite port and the field contact model
`default_nettype none

module cir_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import cir_pkg::*;

	logic clk, rst, cmd_first, cmd_remote, fci, rri;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [1:0] bresp, rresp, resp;
	logic [7:0] act;
	int fails = 0;
	int checked = 0;
	int cycles = 0;

	cir_field_model i_cir_field_model (.clk(clk), .rst(rst), .cmd_first(cmd_first), .cmd_remote(cmd_remote),
		.first_control_input(fci), .remote_reset_input(rri));
	cir_top i_cir_top (.clk(clk), .rst(rst), .first_control_input(fci), .remote_reset_input(rri),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .block_overload(act[0]), .block_unbalance(act[1]),
		.block_undercurrent(act[2]), .inhibit_ext_ctrl(act[3]), .ext_trip(act[4]),
		.clear_indicators(act[5]), .release_relays(act[6]), .master_reset(act[7]));

	// ---------------------------------------------------------------
	// shared tasks
	// ---------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// handshakes are judged at the falling edge, where the values that the
	// next rising edge samples are settled
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		logic aw, w, b;
		aw = 1'b1;
		w = 1'b1;
		b = 1'b0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!b) begin
			@(negedge clk);
			if (aw && awready === 1'b1) aw = 1'b0;
			if (w && wready === 1'b1) w = 1'b0;
			b = (bvalid === 1'b1);
			resp = bresp;
			@(posedge clk);
			if (!aw) awvalid <= 1'b0;
			if (!w) wvalid <= 1'b0;
			if (b) bready <= 1'b0;
		end
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
		logic ar, r;
		ar = 1'b1;
		r = 1'b0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!r) begin
			@(negedge clk);
			if (ar && arready === 1'b1) ar = 1'b0;
			r = (rvalid === 1'b1);
			d = rdata;
			resp = rresp;
			@(posedge clk);
			if (!ar) arvalid <= 1'b0;
			if (r) rready <= 1'b0;
		end
	endtask

	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk);
	endtask

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_reset();
		logic [31:0] d;
		axi_rd(OFS_FIRST_CFG, d);
		check(d, 32'h0, "first cfg reset");
		axi_rd(OFS_REMOTE_CFG, d);
		check(d, 32'h0, "remote cfg reset");
		check({24'h0, act}, 32'h0, "actions after reset");
	endtask

	// no switch, then every switch alone, for one input; the other input idles
	task automatic t_switches(input logic remote);
		logic [31:0] d;
		logic [7:0] exp;
		for (int b = -1; b < 8; b++) begin
			exp = (b < 0) ? 8'h00 : (b == SW_CLR_ALL) ? 8'h60 : 8'h01 << b;
			axi_wr(remote ? OFS_REMOTE_CFG : OFS_FIRST_CFG, {24'h0, (b < 0) ? 8'h00 : 8'h01 << b}, 4'hf);
			@(posedge clk);
			if (remote) cmd_remote <= 1'b1;
			else cmd_first <= 1'b1;
			wait_clk(6);
			if (!remote) check({24'h0, act}, {24'h0, exp}, "first active");
			else check({24'h0, act}, {24'h0, exp}, "remote active");
			axi_rd(OFS_STATUS, d);
			check(d, {22'h0, exp, remote, !remote}, "status word");
			cmd_first <= 1'b0;
			cmd_remote <= 1'b0;
			wait_clk(6);
			check({24'h0, act}, 32'h0, "input released");
		end
		axi_wr(remote ? OFS_REMOTE_CFG : OFS_FIRST_CFG, 32'h0, 4'hf);
	endtask

	// config change under a held input, both inputs, refused accesses
	task automatic t_regs();
		logic [31:0] d;
		axi_wr(OFS_FIRST_CFG, 32'h01, 4'hf);
		axi_wr(OFS_REMOTE_CFG, 32'h04, 4'hf);
		@(posedge clk);
		cmd_first <= 1'b1;
		cmd_remote <= 1'b1;
		wait_clk(6);
		check({24'h0, act}, 32'h05, "both inputs");
		axi_wr(OFS_FIRST_CFG, 32'h18, 4'hf);
		// the outputs follow a new switchgroup one clock after it is written
		wait_clk(2);
		check({24'h0, act}, 32'h1c, "cfg change held");
		axi_wr(OFS_FIRST_CFG, 32'h80, 4'h0);
		check({30'h0, resp}, {30'h0, RESP_OKAY}, "no strobe resp");
		axi_rd(OFS_FIRST_CFG, d);
		check(d, 32'h18, "no strobe data");
		axi_wr(8'h0c, 32'hff, 4'hf);
		check({30'h0, resp}, {30'h0, RESP_SLVERR}, "unmapped write");
		axi_wr(OFS_STATUS, 32'hff, 4'hf);
		check({30'h0, resp}, {30'h0, RESP_SLVERR}, "status write");
		axi_rd(8'h10, d);
		check(d, 32'h0, "unmapped read data");
		check({30'h0, resp}, {30'h0, RESP_SLVERR}, "unmapped read");
		check({24'h0, act}, 32'h1c, "actions kept");
		cmd_first <= 1'b0;
		cmd_remote <= 1'b0;
		wait_clk(6);
	endtask

	// a slow master: response and read data must stand until taken
	task automatic t_slow_resp();
		@(posedge clk);
		awaddr <= OFS_REMOTE_CFG;
		wdata <= 32'h20;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do @(negedge clk); while (awready !== 1'b1 || wready !== 1'b1);
		@(posedge clk);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		do @(negedge clk); while (bvalid !== 1'b1);
		repeat (3) @(negedge clk);
		check({30'h0, bvalid, bresp == RESP_OKAY}, 32'h3, "late write response");
		@(posedge clk);
		bready <= 1'b1;
		@(posedge clk);
		bready <= 1'b0;
		@(posedge clk);
		araddr <= OFS_REMOTE_CFG;
		arvalid <= 1'b1;
		do @(negedge clk); while (arready !== 1'b1);
		@(posedge clk);
		arvalid <= 1'b0;
		do @(negedge clk); while (rvalid !== 1'b1);
		repeat (3) @(negedge clk);
		check(rdata, 32'h20, "late read data");
		check({31'h0, rvalid}, 32'h1, "late read valid");
		@(posedge clk);
		rready <= 1'b1;
		@(posedge clk);
		rready <= 1'b0;
		wait_clk(2);
	endtask

	// ---------------------------------------------------------------
	// clock, reset, timeout, sequence
	// ---------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			give_verdict();
		end
	end

	initial begin
		rst = 1'b1;
		{cmd_first, cmd_remote, awvalid, wvalid, bready, arvalid, rready} = 7'h0;
		{awaddr, araddr, wdata, wstrb} = 52'h0;
		wait_clk(3);
		rst <= 1'b0;
		wait_clk(2);
		t_reset();
		t_switches(1'b0);
		t_switches(1'b1);
		t_regs();
		t_slow_resp();
		give_verdict();
	end
endmodule

`default_nettype wire
